/* File: logic/fault_status_bank.sv */
// Purpose: Fault status summary word with voltage and current detail flags
// Assumes: Bus clock far slower than clk_sys; host obeys byte/word framing
// Notes:   Open-drain sda; output enable low while pulling low
`timescale 1ns/100ps
`default_nettype none
`include "fault_status_regs.svh"
module fault_status_bank
  import fault_status_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `SMB_ADDR_DEFAULT
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic [7:0] vout_events,
  input  wire logic [7:0] iout_events,
  input  wire logic       input_fault,
  input  wire logic       vendor_fault,
  input  wire logic       other_fault,
  input  wire logic       off_live,
  input  wire logic       temp_fault,
  input  wire logic       cml_fault,
  input  wire logic       vin_uv_fault,
  input  wire logic       busy_event,
  input  wire logic       fault_flag_a_event,
  input  wire logic       power_good_pin,
  output logic [15:0]     status_word,
  output logic [7:0]      alert_mask
);
  import fault_status_pkg::*;

  // ==================================================================
  // Reset and pin synchronisers
  logic       rst_q1;
  logic       rst_n_sync;
  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       pg_s;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1     <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_q1     <= 1'b1;
      rst_n_sync <= rst_q1;
    end
  end
  // Bus lines reset to their idle high level, so no false edge follows reset
  pin_sync #(.WIDTH(3), .RESET_VAL(3'h6)) u_sync (
    .clk_sys    (clk_sys),
    .rst_n_sync (rst_n_sync),
    .din        ({scl_in, sda_in, power_good_pin}),
    .dout       (pins_s)
  );
  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign pg_s  = pins_s[0];

  // ==================================================================
  // Bus edge and condition detection
  logic scl_d_reg;
  logic sda_d_reg;
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ==================================================================
  // Serial target
  smb_state_t state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic       rd_mode_reg;
  logic [7:0] cmd_reg;
  logic [7:0] data_lo_reg;
  logic       sda_low_reg;
  logic       wr_byte_pulse;
  logic       wr_word_pulse;
  logic       clear_all_pulse;
  logic [7:0] tx_byte;
  logic [7:0] wr_data;
  logic [7:0] status_low;
  logic [7:0] vout_flags;
  logic [7:0] iout_flags;
  logic       fault_flag_a_reg;
  logic       busy_reg;
  logic       bits_seen_reg;
  logic [7:0] hi_byte;

  // Read byte selected by command code and byte index
  function automatic logic [7:0] read_mux(input logic [7:0] cmd, input logic idx);
    logic [7:0] r;
    r = 8'h00;
    if (cmd == `CMD_STATUS_BYTE) begin
      r = status_low;
    end else if (cmd == `CMD_SUMMARY_WORD) begin
      r = idx ? status_word[15:8] : status_word[7:0];
    end else if (cmd == `CMD_VOUT_FLAGS) begin
      r = vout_flags;
    end else if (cmd == `CMD_IOUT_FLAGS) begin
      r = iout_flags;
    end else if (cmd == `CMD_ALERT_MASK) begin
      r = alert_mask;
    end
    return r;
  endfunction : read_mux

  assign tx_byte = read_mux(cmd_reg, byte_idx_reg[0]);
  assign hi_byte = read_mux(cmd_reg, 1'b1);

  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg    <= st_idle;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      byte_idx_reg <= 2'h0;
      rd_mode_reg  <= 1'b0;
      cmd_reg      <= 8'h00;
      data_lo_reg  <= 8'h00;
      sda_low_reg  <= 1'b0;
      bits_seen_reg <= 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps command, restarts address phase
      state_reg    <= st_shift;
      bit_cnt_reg  <= 3'h0;
      byte_idx_reg <= 2'h0;
      rd_mode_reg  <= 1'b0;
      sda_low_reg  <= 1'b0;
      bits_seen_reg <= 1'b0;
    end else if (stop_cond) begin
      state_reg   <= st_idle;
      sda_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        st_shift: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            bits_seen_reg <= 1'b1;
          end else if (scl_fall && bit_cnt_reg == 3'h0 && bits_seen_reg) begin
            // The start condition's own clock fall must not count as a byte end
            bits_seen_reg <= 1'b0;
            state_reg <= st_ack;
            if (byte_idx_reg == 2'h0 && shift_reg[7:1] != TARGET_ADDR) begin
              state_reg <= st_skip;
            end else begin
              sda_low_reg <= 1'b1;
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            sda_low_reg <= 1'b0;
            state_reg   <= st_shift;
            if (byte_idx_reg == 2'h0) begin
              rd_mode_reg  <= shift_reg[0];
              byte_idx_reg <= 2'h1;
              if (shift_reg[0]) begin
                state_reg    <= st_send;
                byte_idx_reg <= 2'h0;
                shift_reg    <= tx_byte;
                sda_low_reg  <= ~tx_byte[7];
              end
            end else if (byte_idx_reg == 2'h1) begin
              cmd_reg      <= shift_reg;
              byte_idx_reg <= 2'h2;
            end else if (byte_idx_reg == 2'h2) begin
              data_lo_reg  <= shift_reg;
              byte_idx_reg <= 2'h3;
            end else begin
              // Word high byte done; further bytes are ignored
              state_reg <= st_skip;
            end
          end
        end
        st_send: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_reg   <= st_rack;
              sda_low_reg <= 1'b0;
            end else begin
              shift_reg   <= {shift_reg[6:0], 1'b0};
              sda_low_reg <= ~shift_reg[6];
            end
          end
        end
        st_rack: begin
          if (scl_rise) begin
            rd_mode_reg <= ~sda_s;
          end else if (scl_fall) begin
            if (rd_mode_reg) begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
              shift_reg    <= hi_byte;
              sda_low_reg  <= ~hi_byte[7];
              state_reg    <= st_send;
            end else begin
              state_reg <= st_skip;
            end
          end
        end
        default: begin
          sda_low_reg <= 1'b0;
        end
      endcase
    end
  end

  // Byte write is data byte completed at its ack; word write on second
  logic data_acked;
  assign data_acked    = state_reg == st_ack && scl_fall && !rd_mode_reg;
  assign wr_byte_pulse = data_acked && byte_idx_reg == 2'h2 && cmd_reg != `CMD_SUMMARY_WORD;
  assign wr_word_pulse = data_acked && byte_idx_reg == 2'h3 && cmd_reg == `CMD_SUMMARY_WORD;
  assign wr_data       = shift_reg;
  // Send-byte: command byte acked then stop; taken at the command ack
  assign clear_all_pulse = data_acked && byte_idx_reg == 2'h1 && shift_reg == `CMD_CLEAR_FAULTS;

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_low_reg;

  // ==================================================================
  // Detail flags
  w1c_flags #(.IMPL(`VOUT_IMPL_MASK)) u_vout (
    .clk_sys    (clk_sys),
    .rst_n_sync (rst_n_sync),
    .set_ev     (vout_events),
    .clr_bits   (wr_byte_pulse && cmd_reg == `CMD_VOUT_FLAGS ? wr_data : 8'h00),
    .clr_all    (clear_all_pulse),
    .flags      (vout_flags)
  );
  w1c_flags #(.IMPL(`IOUT_IMPL_MASK)) u_iout (
    .clk_sys    (clk_sys),
    .rst_n_sync (rst_n_sync),
    .set_ev     (iout_events),
    .clr_bits   (wr_byte_pulse && cmd_reg == `CMD_IOUT_FLAGS ? wr_data : 8'h00),
    .clr_all    (clear_all_pulse),
    .flags      (iout_flags)
  );

  // ==================================================================
  // Busy and fault_flag_a-fault flags, set wins over clear
  logic clr_busy;
  logic clr_flag_a;
  assign clr_busy   = clear_all_pulse
                    | (wr_byte_pulse && cmd_reg == `CMD_STATUS_BYTE && wr_data[`BIT_BUSY])
                    | (wr_word_pulse && data_lo_reg[`BIT_BUSY]);
  assign clr_flag_a = clear_all_pulse | (wr_word_pulse && wr_data[0]);
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      busy_reg         <= 1'b0;
      fault_flag_a_reg <= 1'b0;
    end else begin
      busy_reg         <= busy_event | (busy_reg & ~clr_busy);
      fault_flag_a_reg <= fault_flag_a_event | (fault_flag_a_reg & ~clr_flag_a);
    end
  end

  // Alert mask, one bit per alert-capable status byte bit
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      alert_mask <= `BYTE_RESET;
    end else if (wr_byte_pulse && cmd_reg == `CMD_ALERT_MASK) begin
      alert_mask <= wr_data;
    end
  end

  // ==================================================================
  // Summary assembly, recomputed every cycle from the details
  always_comb begin
    status_low                  = 8'h00;
    status_low[`BIT_BUSY]       = busy_reg;
    status_low[`BIT_OFF]        = off_live;
    status_low[`BIT_VOUT_OV]    = vout_flags[7];
    status_low[`BIT_IOUT_OC]    = iout_flags[7];
    status_low[`BIT_VIN_UV]     = vin_uv_fault;
    status_low[`BIT_TEMP]       = temp_fault;
    status_low[`BIT_CML]        = cml_fault;
    status_low[`BIT_NONE_ABOVE] = fault_flag_a_reg;
  end
  logic [15:0] word_next;
  always_comb begin
    word_next                = {8'h00, status_low};
    word_next[`BIT_W_VOUT]   = |vout_flags;
    word_next[`BIT_W_IOUT]   = |iout_flags;
    word_next[`BIT_W_INPUT]  = input_fault;
    word_next[`BIT_W_VENDOR] = vendor_fault;
    word_next[`BIT_W_POWER_GOOD_LIVE]  = pg_s;
    word_next[`BIT_W_OTHER]  = other_fault;
  end
  assign status_word = word_next;

  // ==================================================================
  // Checks
  property p_vout_sum;
    @(posedge clk_sys) disable iff (!rst_n_sync) status_word[`BIT_W_VOUT] == (|vout_flags);
  endproperty
  a_vout_sum: assert property (p_vout_sum) else $error("vout summary wrong");
  property p_iout_sum;
    @(posedge clk_sys) disable iff (!rst_n_sync) status_word[`BIT_W_IOUT] == (|iout_flags);
  endproperty
  a_iout_sum: assert property (p_iout_sum) else $error("iout summary wrong");
  property p_zero_bits;
    @(posedge clk_sys) disable iff (!rst_n_sync) !status_word[10] && !status_word[8];
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("bits 10/8 set");
  property p_vout_low;
    @(posedge clk_sys) disable iff (!rst_n_sync) vout_flags[1:0] == 2'b00 && iout_flags[6] == 1'b0;
  endproperty
  a_vout_low: assert property (p_vout_low) else $error("unimplemented flag set");
  property p_latch;
    @(posedge clk_sys) disable iff (!rst_n_sync) vout_events[7] |=> vout_flags[7];
  endproperty
  a_latch: assert property (p_latch) else $error("ov fault not latched");
  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      vout_flags[4] && !clear_all_pulse && !wr_byte_pulse |=> vout_flags[4];
  endproperty
  a_hold: assert property (p_hold) else $error("uv fault lost");
  property p_clear_all;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      clear_all_pulse && !iout_events[5] |=> !iout_flags[5];
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear faults ignored");
  property p_busy_clr;
    @(posedge clk_sys) disable iff (!rst_n_sync)
      wr_word_pulse && data_lo_reg[7] && !busy_event |=> !status_word[7];
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");
  property p_pg;
    @(posedge clk_sys) disable iff (!rst_n_sync) status_word[`BIT_W_POWER_GOOD_LIVE] == $past(power_good_pin, 2);
  endproperty
  a_pg: assert property (p_pg) else $error("power good copy wrong");
  c_word_wr: cover property (@(posedge clk_sys) disable iff (!rst_n_sync) wr_word_pulse);
  c_clear:   cover property (@(posedge clk_sys) disable iff (!rst_n_sync) clear_all_pulse);
  c_read:    cover property (@(posedge clk_sys) disable iff (!rst_n_sync) state_reg == st_send);
endmodule : fault_status_bank
`default_nettype wire

/* File: logic/fault_status_regs.svh */
// Purpose: Command codes, bit positions and masks for the fault status bank
// Assumes: 10 MHz system clock, SMBus-style target on scl/sda pins
// Notes:   Macros only; the types live in the package
// Behaviour
// - Summary word at 79h, read/write word
// - Word low byte is the status byte
// - Bit 15 flags output voltage fault
// - Bit 14 flags output current fault
// - Bit 13 flags input fault
// - Bit 12 flags vendor fault
// - Bit 11 live power good pin copy
// - Bits 10 and 8 read zero
// - Bit 9 flags other fault
// - Word write 0080h clears busy
// - Word write 0180h clears busy, fault_flag_a
// - Alert-capable bits have a mask bit
// - Voltage detail at 7Ah, byte access
// - Voltage flags clear by command or W1C
// - Voltage bit 7 latches overvoltage fault
// - Voltage bit 6 latches overvoltage warning
// - Voltage bit 5 latches undervoltage warning
// - Voltage bit 4 latches undervoltage fault
// - Bits 3,2 latch limit and timeout
// - Voltage bits 1:0 read zero
// - Current detail at 7Bh, clearable
// - Current bits 7,5 latch fault, warning
// - Byte write 80h clears busy
// - Summary bits follow detail flags
`ifndef FAULT_STATUS_REGS_SVH
`define FAULT_STATUS_REGS_SVH
`define CMD_STATUS_BYTE   8'h78
`define CMD_SUMMARY_WORD  8'h79
`define CMD_VOUT_FLAGS    8'h7a
`define CMD_IOUT_FLAGS    8'h7b
`define CMD_CLEAR_FAULTS  8'h03
`define CMD_ALERT_MASK    8'h1b
`define BIT_BUSY          7
`define BIT_OFF           6
`define BIT_VOUT_OV       5
`define BIT_IOUT_OC       4
`define BIT_VIN_UV        3
`define BIT_TEMP          2
`define BIT_CML           1
`define BIT_NONE_ABOVE    0
`define BIT_W_VOUT        15
`define BIT_W_IOUT        14
`define BIT_W_INPUT       13
`define BIT_W_VENDOR      12
`define BIT_W_POWER_GOOD_LIVE       11
`define BIT_W_OTHER       9
`define BIT_W_FLAG_A      8
`define VOUT_IMPL_MASK    8'hfc
`define IOUT_IMPL_MASK    8'ha0
`define BYTE_RESET        8'h00
`define SMB_ADDR_DEFAULT  7'h24
`endif

/* File: logic/fault_status_pkg.sv */
// Purpose: Shared types for the fault status bank
// Assumes: Included with fault_status_regs.svh
// Notes:   States of the serial target
`default_nettype none
package fault_status_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_shift = 3'b001,
    st_ack   = 3'b010,
    st_send  = 3'b011,
    st_rack  = 3'b100,
    st_skip  = 3'b101
  } smb_state_t;
endpackage : fault_status_pkg
`default_nettype wire

/* File: logic/pin_sync.sv */
// Purpose: Two-flop synchroniser for pins
// Assumes: Async pins
// Notes:   Stage one read only by stage two
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n_sync,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be at least one");
  end
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      meta_reg <= RESET_VAL;
      dout     <= RESET_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

/* File: logic/w1c_flags.sv */
// Purpose: Latched sticky flag byte with write-one-to-clear
// Assumes: Events are synchronous pulses or levels
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "fault_status_regs.svh"
module w1c_flags #(
  parameter logic [7:0] IMPL = 8'hff
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n_sync,
  input  wire logic [7:0] set_ev,
  input  wire logic [7:0] clr_bits,
  input  wire logic       clr_all,
  output var  logic [7:0] flags
);
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      flags <= `BYTE_RESET;
    end else begin
      // Unimplemented positions stay zero
      flags <= IMPL & (set_ev | (flags & ~(clr_all ? 8'hff : clr_bits)));
    end
  end
endmodule : w1c_flags
`default_nettype wire

/* File: bench/smb_host_model.sv */
// Purpose: Behavioural bus host that frames byte and word transfers
// Assumes: Open-drain data line with its pull-up resolved by the bench
// Notes:   Bus clock idles high between frames; a quarter bit is 2 clk_sys cycles
`timescale 1ns/100ps
`default_nettype none
module smb_host_model #(
  parameter logic [6:0] TARGET = 7'h24
) (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_drv
);
  int nack_total = 0;

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  // ==========================================================
  // Bit level
  task automatic q();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : q

  // Also serves as repeated start from a low bus clock
  task automatic frame_start();
    sda_drv = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask : frame_start

  task automatic frame_stop();
    sda_drv = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b1;
    q();
  endtask : frame_stop

  // Data changes only while the bus clock is low
  task automatic bit_cycle(input logic b, output logic r);
    sda_drv = b;
    q();
    scl = 1'b1;
    q();
    r = sda_line;
    q();
    scl = 1'b0;
    q();
  endtask : bit_cycle

  task automatic put_byte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], r);
    bit_cycle(1'b1, nack);
  endtask : put_byte

  task automatic put_acked(input logic [7:0] b);
    logic n;
    put_byte(b, n);
    nack_total += int'(n);
  endtask : put_acked

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      b[i] = r;
    end
    bit_cycle(last, r);
  endtask : get_byte

  // ==========================================================
  // Transactions
  // nbytes 0 is a bare command such as clear faults
  task automatic write_data(input logic [7:0] cmd, input logic [15:0] data, input int nbytes);
    frame_start();
    put_acked({TARGET, 1'b0});
    put_acked(cmd);
    for (int k = 0; k < nbytes; k++) put_acked(data[8*k +: 8]);
    frame_stop();
  endtask : write_data

  task automatic read_data(input logic [7:0] cmd, input int nbytes, output logic [15:0] data);
    logic [7:0] b;
    data = 16'h0000;
    frame_start();
    put_acked({TARGET, 1'b0});
    put_acked(cmd);
    frame_start();
    put_acked({TARGET, 1'b1});
    for (int k = 0; k < nbytes; k++) begin
      get_byte(k == nbytes - 1, b);
      data[8*k +: 8] = b;
    end
    frame_stop();
  endtask : read_data

  task automatic probe(input logic [6:0] addr, output logic nack);
    frame_start();
    put_byte({addr, 1'b0}, nack);
    frame_stop();
  endtask : probe
endmodule : smb_host_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the fault status bank over the serial bus
// Assumes: Host model drives the bus; events driven just after clk_sys rises
// Notes:   Expected values are literal constants; commands named by their macros, unused 55h by its code
`timescale 1ns/100ps
`default_nettype none
`include "fault_status_regs.svh"
module tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        scl, sda_drv, sda_out, sda_oe_n, sda_line;
  logic [7:0]  vout_ev = 8'h00;
  logic [7:0]  iout_ev = 8'h00;
  logic [6:0]  live    = 7'h00;
  logic        busy_ev = 1'b0;
  logic        flag_ev = 1'b0;
  logic        pg_pin  = 1'b0;
  logic [15:0] status_word;
  logic [7:0]  alert_mask;
  logic        nack;
  int          err_total = 0;
  int          checks    = 0;

  always #50 clk_sys = ~clk_sys;
  assign sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_out);

  fault_status_bank dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .vout_events(vout_ev), .iout_events(iout_ev),
    .input_fault(live[0]), .vendor_fault(live[1]), .other_fault(live[2]), .off_live(live[3]),
    .temp_fault(live[4]), .cml_fault(live[5]), .vin_uv_fault(live[6]), .busy_event(busy_ev),
    .fault_flag_a_event(flag_ev), .power_good_pin(pg_pin), .status_word(status_word),
    .alert_mask(alert_mask)
  );

  smb_host_model host_u (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] cmd, input int n, input logic [15:0] exp);
    logic [15:0] v;
    host_u.read_data(cmd, n, v);
    check($sformatf("cmd %h", cmd), v, exp);
  endtask : rd_chk

  // One-cycle set pulses
  task automatic pulse(input logic [7:0] v, input logic [7:0] i, input logic b, input logic f);
    @(posedge clk_sys);
    #1;
    {vout_ev, iout_ev, busy_ev, flag_ev} = {v, i, b, f};
    @(posedge clk_sys);
    #1;
    {vout_ev, iout_ev, busy_ev, flag_ev} = '0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : pulse

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    rd_chk(`CMD_SUMMARY_WORD, 2, 16'h0000);
    rd_chk(`CMD_VOUT_FLAGS, 1, 16'h0000);
    rd_chk(`CMD_IOUT_FLAGS, 1, 16'h0000);
    $display("test reset done");

    pulse(8'hff, 8'h00, 1'b0, 1'b0);
    check("word bit 15", {15'h0000, status_word[15]}, 16'h0001);
    rd_chk(`CMD_VOUT_FLAGS, 1, 16'h00fc);
    host_u.write_data(`CMD_VOUT_FLAGS, 16'h0000, 1);
    rd_chk(`CMD_VOUT_FLAGS, 1, 16'h00fc);
    host_u.write_data(`CMD_VOUT_FLAGS, 16'h0080, 1);
    rd_chk(`CMD_VOUT_FLAGS, 1, 16'h007c);
    check("word bit 15", {15'h0000, status_word[15]}, 16'h0001);
    host_u.write_data(`CMD_VOUT_FLAGS, 16'h007c, 1);
    rd_chk(`CMD_VOUT_FLAGS, 1, 16'h0000);
    check("word bit 15", {15'h0000, status_word[15]}, 16'h0000);
    $display("test voltage flags done");

    pulse(8'h00, 8'hff, 1'b0, 1'b0);
    check("word bit 14", {15'h0000, status_word[14]}, 16'h0001);
    rd_chk(`CMD_IOUT_FLAGS, 1, 16'h00a0);
    host_u.write_data(`CMD_IOUT_FLAGS, 16'h0020, 1);
    rd_chk(`CMD_IOUT_FLAGS, 1, 16'h0080);
    pulse(8'h04, 8'h00, 1'b0, 1'b0);
    host_u.write_data(`CMD_CLEAR_FAULTS, 16'h0000, 0);
    rd_chk(`CMD_IOUT_FLAGS, 1, 16'h0000);
    rd_chk(`CMD_VOUT_FLAGS, 1, 16'h0000);
    check("word bits 15:14", {14'h0000, status_word[15:14]}, 16'h0000);
    $display("test current flags done");

    pulse(8'h00, 8'h00, 1'b1, 1'b1);
    rd_chk(`CMD_SUMMARY_WORD, 2, 16'h0081);
    host_u.write_data(`CMD_SUMMARY_WORD, 16'h0080, 2);
    rd_chk(`CMD_SUMMARY_WORD, 2, 16'h0001);
    pulse(8'h00, 8'h00, 1'b1, 1'b0);
    host_u.write_data(`CMD_SUMMARY_WORD, 16'h0180, 2);
    rd_chk(`CMD_SUMMARY_WORD, 2, 16'h0000);
    pulse(8'h00, 8'h00, 1'b1, 1'b0);
    rd_chk(`CMD_STATUS_BYTE, 1, 16'h0080);
    host_u.write_data(`CMD_STATUS_BYTE, 16'h0080, 1);
    rd_chk(`CMD_SUMMARY_WORD, 2, 16'h0000);
    $display("test busy and fault_flag_a done");

    @(posedge clk_sys);
    #1;
    live   = 7'h7f;
    pg_pin = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    check("live word", status_word, 16'h3a4e);
    rd_chk(`CMD_SUMMARY_WORD, 2, 16'h3a4e);
    @(posedge clk_sys);
    #1;
    pg_pin = 1'b0;
    live   = 7'h00;
    repeat (5) @(posedge clk_sys);
    #1;
    check("live word", status_word, 16'h0000);
    $display("test live bits done");

    host_u.write_data(`CMD_ALERT_MASK, 16'h005a, 1);
    rd_chk(`CMD_ALERT_MASK, 1, 16'h005a);
    check("mask port", {8'h00, alert_mask}, 16'h005a);
    rd_chk(8'h55, 1, 16'h0000);
    host_u.probe(7'h25, nack);
    check("foreign address ack", {15'h0000, nack}, 16'h0001);
    check("nacks", 16'(host_u.nack_total), 16'h0000);
    $display("test mask and refusals done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
